// ---- design/serial_flash_command_status.sv ----
`timescale 1ns/1ps
module serial_flash_command_status (
   input wire logic clk,
   input wire logic rstn,
   input wire logic sck,
   input wire logic csN,
   input wire logic si,
   input wire logic wpN,
   output logic so,
   output logic soEn,
   output logic [7:0] deviceStatusFlags,
   input wire logic arrayBusy,
   input wire logic xferDone,
   output logic progStart,
   output logic [serial_flash_pkg::FIELD_W-1:0] progSector,
   output logic xferStart,
   output logic xferToPb,
   output logic cfgWrite,
   output logic [serial_flash_pkg::FIELD_W-1:0] cfgWriteValue,
   output logic [serial_flash_pkg::FIELD_W-1:0] linkSector,
   output logic [serial_flash_pkg::BYTE_ADDR_W-1:0] memAddr,
   input wire logic [7:0] sectorByte,
   input wire logic [7:0] sramByte,
   input wire logic [7:0] pbByte,
   input wire logic [serial_flash_pkg::FIELD_W-1:0] cfgValue,
   output logic sramWrEn,
   output logic [serial_flash_pkg::BYTE_ADDR_W-1:0] sramWrAddr,
   output logic [7:0] sramWrData
);
   import serial_flash_pkg::*;
   // commands that answer with a status word and then data
   function automatic logic isReadType(input logic [7:0] op);
      isReadType = (op == OP_READ_SECTOR) || (op == OP_READ_SECTOR_LF) ||
                   (op == OP_READ_SRAM) || (op == OP_READ_PB) ||
                   (op == OP_READ_CFG) || (op == OP_READ_STATUS);
   endfunction : isReadType
   // commands whose data phase follows the byte field directly
   function automatic logic isWriteType(input logic [7:0] op);
      isWriteType = (op == OP_WRITE_SECTOR) || (op == OP_WRITE_SRAM) ||
                    (op == OP_SECTOR_TO_SRAM);
   endfunction : isWriteType
   // byte address walks up and wraps after the last buffer byte
   function automatic logic [BYTE_ADDR_W-1:0] nextAddr(
      input logic [BYTE_ADDR_W-1:0] a);
      nextAddr = (a == LAST_BYTE_ADDR) ? FIRST_BYTE_ADDR :
                 a + {{(BYTE_ADDR_W-1){1'b0}}, 1'b1};
   endfunction : nextAddr
   // link side, clocked by sck
   // frame reset: select high clears the started flag and the serial output flops; a glitch on csN only
   // restarts the frame, which the host must avoid anyway
   logic linkRstN;
   assign linkRstN = rstn & ~csN;
   logic startedFf, nxt_started;
   logic [39:0] hdrFf, nxt_hdr;
   logic [7:0] opcodeFf, nxt_opcode;
   logic [6:0] hdrCntFf, nxt_hdrCnt;
   logic [2:0] bitInByteFf, nxt_bitInByte;
   logic [BYTE_ADDR_W-1:0] byteAddrFf, nxt_byteAddr;
   logic [7:0] shiftByteFf, nxt_shiftByte;
   logic sramWrEnFf, nxt_sramWrEn;
   logic [BYTE_ADDR_W-1:0] sramWrAddrFf, nxt_sramWrAddr;
   logic [7:0] sramWrDataFf, nxt_sramWrData;
   logic cmpToggleFf, nxt_cmpToggle;
   logic [7:0] statSync1Ff, statSync2Ff;
   logic [7:0] statusFf;
   logic [6:0] cnt;
   logic [6:0] dataStart;
   logic inData, byteDone, busyL, trL;

   assign busyL = statSync2Ff[ST_BUSY];
   assign trL = statSync2Ff[ST_TR];
   // started marks that this frame has seen its first rising edge
   always_comb begin
      nxt_started = 1'b1;
   end
   always_ff @(posedge sck or negedge linkRstN) begin
      if (!linkRstN) begin
         startedFf <= 1'b0;
      end else begin
         startedFf <= nxt_started;
      end
   end

   // shifter, counters and buffer write port; these keep their value
   // after select rises so the system side can decode the frame
   always_comb begin
      cnt = startedFf ? hdrCntFf : 7'h00;
      dataStart = isWriteType(opcodeFf) ? CNT_BYTE : CNT_DATA;
      inData = (cnt >= CNT_OPCODE) && (cnt >= dataStart);
      byteDone = inData && (bitInByteFf == LAST_BIT);
      nxt_hdr = (cnt < CNT_BYTE) ? {hdrFf[38:0], si} : hdrFf;
      nxt_opcode = (cnt == CNT_OPCODE_LAST) ? {hdrFf[6:0], si} : opcodeFf;
      nxt_hdrCnt = (cnt == CNT_DATA) ? cnt : cnt + CNT_ONE;
      nxt_bitInByte = inData ? bitInByteFf + 3'h1 : 3'h0;
      nxt_shiftByte = {shiftByteFf[6:0], si};
      nxt_byteAddr = byteAddrFf;
      if (cnt == CNT_BYTE_LAST) begin
         nxt_byteAddr = {hdrFf[8:0], si};
      end else if (byteDone) begin
         nxt_byteAddr = nextAddr(byteAddrFf);
      end
      // host data and sector copies both go through the SRAM port
      nxt_sramWrEn = 1'b0;
      if (byteDone) begin
         case (opcodeFf)
            OP_WRITE_SECTOR: nxt_sramWrEn = !busyL;
            OP_WRITE_SRAM: nxt_sramWrEn = !(busyL && !trL);
            OP_SECTOR_TO_SRAM: nxt_sramWrEn = !busyL;
            default: nxt_sramWrEn = 1'b0;
         endcase
      end
      nxt_sramWrAddr = byteDone ? byteAddrFf : sramWrAddrFf;
      nxt_sramWrData = sramWrDataFf;
      if (byteDone) begin
         nxt_sramWrData = (opcodeFf == OP_SECTOR_TO_SRAM) ? sectorByte :
                          {shiftByteFf[6:0], si};
      end
      // compare one bit per clock; each mismatch flips the toggle while the array is not busy
      nxt_cmpToggle = cmpToggleFf;
      if (inData && (opcodeFf == OP_COMPARE) && !busyL &&
          (sectorByte[LAST_BIT - bitInByteFf] !=
           sramByte[LAST_BIT - bitInByteFf])) begin
         nxt_cmpToggle = ~cmpToggleFf;
      end
   end

   always_ff @(posedge sck or negedge rstn) begin
      if (!rstn) begin
         hdrFf <= '0;
         opcodeFf <= 8'h00;
         hdrCntFf <= 7'h00;
         bitInByteFf <= 3'h0;
         byteAddrFf <= FIRST_BYTE_ADDR;
         shiftByteFf <= 8'h00;
         sramWrEnFf <= 1'b0;
         sramWrAddrFf <= FIRST_BYTE_ADDR;
         sramWrDataFf <= 8'h00;
         cmpToggleFf <= 1'b0;
         statSync1Ff <= STATUS_RESET;
         statSync2Ff <= STATUS_RESET;
      end else begin
         hdrFf <= nxt_hdr;
         opcodeFf <= nxt_opcode;
         hdrCntFf <= nxt_hdrCnt;
         bitInByteFf <= nxt_bitInByte;
         byteAddrFf <= nxt_byteAddr;
         shiftByteFf <= nxt_shiftByte;
         sramWrEnFf <= nxt_sramWrEn;
         sramWrAddrFf <= nxt_sramWrAddr;
         sramWrDataFf <= nxt_sramWrData;
         cmpToggleFf <= nxt_cmpToggle;
         statSync1Ff <= statusFf; // status level crossing, stage one
         statSync2Ff <= statSync1Ff;
      end
   end

   // serial output, launched on the falling edge for a rising-edge host
   logic soFf, nxt_so, soEnFf, nxt_soEn;
   logic [15:0] rbWord;
   logic [6:0] rbIdxFull;
   logic [7:0] dataByte;

   always_comb begin
      rbWord = busyL ? RB_BUSY : RB_READY;
      rbIdxFull = CNT_DATA - CNT_ONE - hdrCntFf;
      case (opcodeFf)
         OP_READ_SECTOR, OP_READ_SECTOR_LF: dataByte = sectorByte;
         OP_READ_SRAM: dataByte = sramByte;
         OP_READ_PB: dataByte = pbByte;
         OP_READ_CFG: dataByte = byteAddrFf[0] ? cfgValue[15:8] :
                                 cfgValue[7:0];
         OP_READ_STATUS: dataByte = statSync2Ff;
         default: dataByte = 8'h00;
      endcase
      nxt_soEn = startedFf && (hdrCntFf >= CNT_RB) &&
                 (isReadType(opcodeFf) ||
                  ((opcodeFf == OP_COMPARE) && (hdrCntFf < CNT_DATA)));
      if (hdrCntFf < CNT_DATA) begin
         nxt_so = rbWord[rbIdxFull[3:0]];
      end else begin
         nxt_so = dataByte[LAST_BIT - bitInByteFf];
      end
      if (!nxt_soEn) begin
         nxt_so = 1'b0;
      end
   end

   always_ff @(negedge sck or negedge linkRstN) begin
      if (!linkRstN) begin
         soFf <= 1'b0;
         soEnFf <= 1'b0;
      end else begin
         soFf <= nxt_so;
         soEnFf <= nxt_soEn;
      end
   end
   assign so = soFf;
   assign soEn = soEnFf;
   assign memAddr = byteAddrFf;
   assign linkSector = hdrFf[31:16];
   assign sramWrEn = sramWrEnFf;
   assign sramWrAddr = sramWrAddrFf;
   assign sramWrData = sramWrDataFf;
   // system side, clocked by clk
   // two-stage synchronisers; third stages only feed edge detectors
   logic csS1Ff, csS2Ff, csPrevFf;
   logic wpS1Ff, wpS2Ff;
   logic cmpS1Ff, cmpS2Ff, cmpS3Ff;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         csS1Ff <= 1'b1;
         csS2Ff <= 1'b1;
         csPrevFf <= 1'b1;
         wpS1Ff <= 1'b0;
         wpS2Ff <= 1'b0;
         cmpS1Ff <= 1'b0;
         cmpS2Ff <= 1'b0;
         cmpS3Ff <= 1'b0;
      end else begin
         csS1Ff <= csN;
         csS2Ff <= csS1Ff;
         csPrevFf <= csS2Ff;
         wpS1Ff <= wpN;
         wpS2Ff <= wpS1Ff;
         cmpS1Ff <= cmpToggleFf;
         cmpS2Ff <= cmpS1Ff;
         cmpS3Ff <= cmpS2Ff;
      end
   end
   logic csRise, mismatch, frameOk, fullHdr, clrCmp;
   assign csRise = csS2Ff && !csPrevFf;
   assign mismatch = cmpS2Ff ^ cmpS3Ff;
   // command completion: the link fields are frozen because sck has
   // stopped once select is high, so they are read directly here
   logic busyFf, nxt_busy, trFf, nxt_tr, weFf, nxt_we, cneFf, nxt_cne;
   logic progStartFf, nxt_progStart, xferStartFf, nxt_xferStart;
   logic xferToPbFf, nxt_xferToPb, cfgWriteFf, nxt_cfgWrite;
   logic [FIELD_W-1:0] progSectorFf, nxt_progSector;
   logic [FIELD_W-1:0] cfgWriteValueFf, nxt_cfgWriteValue;

   always_comb begin
      frameOk = hdrCntFf >= CNT_OPCODE;
      fullHdr = hdrCntFf >= CNT_BYTE;
      clrCmp = 1'b0;
      nxt_we = weFf;
      nxt_progStart = 1'b0;
      nxt_progSector = progSectorFf;
      nxt_xferStart = 1'b0;
      nxt_xferToPb = xferToPbFf;
      nxt_cfgWrite = 1'b0;
      nxt_cfgWriteValue = cfgWriteValueFf;
      if (csRise && frameOk) begin
         case (opcodeFf)
            OP_WRITE_ENABLE: nxt_we = wpS2Ff;
            OP_WRITE_DISABLE: nxt_we = 1'b0;
            OP_WRITE_SECTOR: begin
               if (fullHdr && weFf && wpS2Ff && !busyFf) begin
                  nxt_progStart = 1'b1;
                  nxt_progSector = hdrFf[31:16];
               end
            end
            OP_SRAM_TO_PB, OP_PB_TO_SRAM: begin
               if (fullHdr && !busyFf) begin
                  nxt_xferStart = 1'b1;
                  nxt_xferToPb = opcodeFf == OP_SRAM_TO_PB;
               end
            end
            OP_WRITE_CFG: begin
               if (fullHdr && !busyFf) begin
                  nxt_cfgWrite = 1'b1;
                  nxt_cfgWriteValue = hdrFf[31:16];
               end
            end
            OP_CLEAR_COMPARE: clrCmp = 1'b1;
            default: clrCmp = 1'b0;
         endcase
      end
      // set wins over clear for both sticky flags
      nxt_tr = nxt_xferStart ? 1'b1 : (xferDone ? 1'b0 : trFf);
      nxt_busy = arrayBusy || nxt_tr;
      nxt_cne = mismatch ? 1'b1 : (clrCmp ? 1'b0 : cneFf);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busyFf <= 1'b0;
         trFf <= 1'b0;
         weFf <= 1'b0;
         cneFf <= 1'b0;
         progStartFf <= 1'b0;
         progSectorFf <= '0;
         xferStartFf <= 1'b0;
         xferToPbFf <= 1'b0;
         cfgWriteFf <= 1'b0;
         cfgWriteValueFf <= '0;
      end else begin
         busyFf <= nxt_busy;
         trFf <= nxt_tr;
         weFf <= nxt_we;
         cneFf <= nxt_cne;
         progStartFf <= nxt_progStart;
         progSectorFf <= nxt_progSector;
         xferStartFf <= nxt_xferStart;
         xferToPbFf <= nxt_xferToPb;
         cfgWriteFf <= nxt_cfgWrite;
         cfgWriteValueFf <= nxt_cfgWriteValue;
      end
   end
   // status byte; unused positions are hard zero
   always_comb begin
      statusFf = STATUS_RESET;
      statusFf[ST_BUSY] = busyFf;
      statusFf[ST_TR] = trFf;
      statusFf[ST_WE] = weFf;
      statusFf[ST_CNE] = cneFf;
   end
   assign deviceStatusFlags = statusFf;
   assign progStart = progStartFf;
   assign progSector = progSectorFf;
   assign xferStart = xferStartFf;
   assign xferToPb = xferToPbFf;
   assign cfgWrite = cfgWriteFf;
   assign cfgWriteValue = cfgWriteValueFf;
   // checks
   AST_BUSY_FOLLOWS:
      assert property (@(posedge clk) disable iff (!rstn)
         arrayBusy |=> deviceStatusFlags[ST_BUSY])
      else $error("busy bit missed array busy");
   AST_TR_START:
      assert property (@(posedge clk) disable iff (!rstn)
         xferStart |-> deviceStatusFlags[ST_TR] ##1 (trFf || $past(xferDone)))
      else $error("transfer flag not set on transfer start");
   AST_TR_BUSY:
      assert property (@(posedge clk) disable iff (!rstn)
         deviceStatusFlags[ST_TR] |-> deviceStatusFlags[ST_BUSY])
      else $error("transfer active without busy");
   AST_WE_SET:
      assert property (@(posedge clk) disable iff (!rstn)
         (csRise && frameOk && opcodeFf == OP_WRITE_ENABLE && wpS2Ff)
         |=> deviceStatusFlags[ST_WE])
      else $error("write enable not reported");
   AST_WE_PROTECT:
      assert property (@(posedge clk) disable iff (!rstn)
         (csRise && frameOk && (opcodeFf == OP_WRITE_DISABLE ||
          (opcodeFf == OP_WRITE_ENABLE && !wpS2Ff)))
         |=> !deviceStatusFlags[ST_WE])
      else $error("write permission set while protected or disabled");
   AST_CNE_CLEAR:
      assert property (@(posedge clk) disable iff (!rstn)
         $fell(cneFf) |-> $past(clrCmp) && !$past(mismatch))
      else $error("mismatch flag cleared without command");
   AST_CNE_SET:
      assert property (@(posedge clk) disable iff (!rstn)
         mismatch |=> deviceStatusFlags[ST_CNE])
      else $error("mismatch flag not set");
   AST_IDLE:
      assert property (@(posedge clk) disable iff (!rstn)
         csS2Ff |-> !soEn)
      else $error("output driven while deselected");
   AST_PROG_GATE:
      assert property (@(posedge clk) disable iff (!rstn)
         progStart |-> $past(weFf) && !$past(busyFf) && $past(csRise))
      else $error("program started while busy or disabled");
   AST_RESERVED:
      assert property (@(posedge clk) disable iff (!rstn)
         deviceStatusFlags[5] == 1'b0 && deviceStatusFlags[2:0] == 3'h0)
      else $error("undefined status bits not zero");
   AST_SRAM_WR_GUARD:
      assert property (@(posedge sck) disable iff (!rstn)
         (sramWrEnFf && opcodeFf == OP_WRITE_SRAM)
         |-> !($past(busyL) && !$past(trL)))
      else $error("SRAM write accepted while busy");
endmodule : serial_flash_command_status

// ---- design/serial_flash_pkg.sv ----
package serial_flash_pkg;
   // command opcodes
   localparam logic [7:0] OP_READ_SECTOR = 8'h52;
   localparam logic [7:0] OP_READ_SECTOR_LF = 8'h51;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_WRITE_SECTOR = 8'hF3;
   localparam logic [7:0] OP_SECTOR_TO_SRAM = 8'h54;
   localparam logic [7:0] OP_COMPARE = 8'h86;
   localparam logic [7:0] OP_WRITE_SRAM = 8'h82;
   localparam logic [7:0] OP_READ_SRAM = 8'h81;
   localparam logic [7:0] OP_SRAM_TO_PB = 8'h92;
   localparam logic [7:0] OP_PB_TO_SRAM = 8'h55;
   localparam logic [7:0] OP_READ_PB = 8'h91;
   localparam logic [7:0] OP_READ_CFG = 8'h8B;
   localparam logic [7:0] OP_WRITE_CFG = 8'h8A;
   localparam logic [7:0] OP_READ_STATUS = 8'h83;
   localparam logic [7:0] OP_CLEAR_COMPARE = 8'h87;

   // status bit positions
   localparam int ST_BUSY = 7;
   localparam int ST_TR = 6;
   localparam int ST_WE = 4;
   localparam int ST_CNE = 3;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // ready/busy words
   localparam logic [15:0] RB_READY = 16'h9999;
   localparam logic [15:0] RB_BUSY = 16'h6666;

   // frame bit counts after which each field is complete
   localparam logic [6:0] CNT_OPCODE_LAST = 7'h07;
   localparam logic [6:0] CNT_OPCODE = 7'h08;
   localparam logic [6:0] CNT_BYTE_LAST = 7'h27;
   localparam logic [6:0] CNT_BYTE = 7'h28;
   localparam logic [6:0] CNT_RB = 7'h38;
   localparam logic [6:0] CNT_DATA = 7'h48;
   localparam logic [6:0] CNT_ONE = 7'h01;

   // buffer geometry
   localparam int BYTE_ADDR_W = 10;
   localparam int FIELD_W = 16;
   localparam logic [9:0] LAST_BYTE_ADDR = 10'h217;
   localparam logic [9:0] FIRST_BYTE_ADDR = 10'h000;
   localparam logic [2:0] LAST_BIT = 3'h7;
endpackage : serial_flash_pkg

// ---- test/spi_host_model.sv ----
`timescale 1ns/1ps
module spi_host_model (
   output logic sck,
   output logic csN,
   output logic si,
   input wire logic so
);
   // link parked: clock stopped low, device deselected
   initial begin
      sck = 1'b0;
      csN = 1'b1;
      si = 1'b0;
   end

   // one whole frame at 12 ns per bit; so is taken on each rising edge
   task automatic frame(input logic [103:0] bits, input int n,
                        output logic [63:0] got);
      got = '0;
      csN = 1'b0;
      for (int k = 0; k < n; k++) begin
         si = bits[103-k];
         #6 sck = 1'b1;
         got = {got[62:0], so};
         #6 sck = 1'b0;
      end
      #2 csN = 1'b1;
      si = ~si; // released line must not keep the last value
      #48; // gap well above three system clocks before the next frame
   endtask : frame
endmodule : spi_host_model

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
   import serial_flash_pkg::*;
   logic clk = 1'b0;
   logic rstn, sck, csN, si, wpN, so, soEn;
   logic arrayBusy, xferDone, progStart, xferStart, xferToPb, cfgWrite;
   logic sramWrEn;
   logic [7:0] deviceStatusFlags, sectorByte, sramByte, pbByte, sramWrData;
   logic [15:0] progSector, cfgWriteValue, linkSector, cfgValue, sec;
   logic [9:0] memAddr, sramWrAddr, a;
   logic [7:0] d;
   logic [63:0] got;
   logic [17:0] wrQ[$];
   logic [7:0] rdOps[5] = '{OP_READ_SECTOR, OP_READ_SECTOR_LF, OP_READ_SRAM,
                            OP_READ_PB, OP_READ_CFG};
   int n_mismatch = 0;
   int comparisons = 0;
   int cycles = 0;
   int nProg = 0;
   int nXfer = 0;
   int nCfg = 0;

   serial_flash_command_status serial_flash_command_status_i (.clk(clk),
      .rstn(rstn), .sck(sck), .csN(csN), .si(si), .wpN(wpN), .so(so),
      .soEn(soEn), .deviceStatusFlags(deviceStatusFlags),
      .arrayBusy(arrayBusy), .xferDone(xferDone), .progStart(progStart),
      .progSector(progSector), .xferStart(xferStart), .xferToPb(xferToPb),
      .cfgWrite(cfgWrite), .cfgWriteValue(cfgWriteValue),
      .linkSector(linkSector), .memAddr(memAddr), .sectorByte(sectorByte),
      .sramByte(sramByte), .pbByte(pbByte), .cfgValue(cfgValue),
      .sramWrEn(sramWrEn), .sramWrAddr(sramWrAddr), .sramWrData(sramWrData));
   spi_host_model spi_host_model_i (.sck(sck), .csN(csN), .si(si), .so(so));

   always #4 clk = ~clk;

   // memory contents differ per store so a wrong source shows up
   function automatic logic [7:0] expB(input logic [7:0] op,
                                       input logic [9:0] x);
      case (op)
         OP_READ_SECTOR, OP_READ_SECTOR_LF: return x[7:0] + 8'h3C;
         OP_READ_PB: return ~x[7:0];
         OP_READ_CFG: return x[0] ? cfgValue[15:8] : cfgValue[7:0];
         default: return x[7:0] ^ 8'hA5;
      endcase
   endfunction : expB

   function automatic logic [9:0] nextA(input logic [9:0] x);
      return (x == LAST_BYTE_ADDR) ? FIRST_BYTE_ADDR : x + 10'h001;
   endfunction : nextA

   assign sectorByte = expB(OP_READ_SECTOR, memAddr);
   assign sramByte = expB(OP_READ_SRAM, memAddr);
   assign pbByte = expB(OP_READ_PB, memAddr);

   // count completion pulses; timeout cuts a hang short
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (progStart === 1'b1) nProg <= nProg + 1;
      if (xferStart === 1'b1) nXfer <= nXfer + 1;
      if (cfgWrite === 1'b1) nCfg <= nCfg + 1;
      if (cycles == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end

   // sampled on falling sck so the last write of a stopped clock is seen
   always @(negedge sck) begin
      if (sramWrEn === 1'b1) wrQ.push_back({sramWrAddr, sramWrData});
   end

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %0h expected %0h", $time, seen, exp);
      end
   endtask : chk

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   task automatic cmd(input logic [7:0] op, input int n);
      spi_host_model_i.frame({op, 96'h0}, n, got);
   endtask : cmd

   task automatic rd(input logic [7:0] op, input logic [15:0] s,
                     input logic [9:0] x, input logic [15:0] rb);
      spi_host_model_i.frame({op, s, 6'h00, x, 64'h0}, 88, got);
      chk(got[31:0], {rb, expB(op, x), expB(op, nextA(x))});
   endtask : rd

   task automatic wrSram(input logic [9:0] x, input logic [7:0] v);
      wrQ.delete();
      spi_host_model_i.frame({OP_WRITE_SRAM, 22'h0, x, v, 56'h0}, 56, got);
   endtask : wrSram

   task automatic pulseDone;
      @(posedge clk) xferDone <= 1'b1;
      @(posedge clk) xferDone <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : pulseDone

   initial begin
      rstn = 1'b0;
      wpN = 1'b1;
      arrayBusy = 1'b0;
      xferDone = 1'b0;
      cfgValue = 16'h0000;
      got = 64'($urandom(7371));
      repeat (6) @(posedge clk);
      chk(deviceStatusFlags, STATUS_RESET);
      chk(soEn, 1'b0);
      rstn <= 1'b1;
      cfgValue <= 16'($urandom);
      repeat (4) @(posedge clk);
      $display("test reset finished");
      // write permission, protect pin low first
      wpN <= 1'b0;
      repeat (4) @(posedge clk);
      cmd(OP_WRITE_ENABLE, 16);
      chk(deviceStatusFlags, 8'h00);
      wpN <= 1'b1;
      repeat (4) @(posedge clk);
      cmd(OP_WRITE_ENABLE, 16);
      chk(deviceStatusFlags, 8'h10);
      cmd(OP_WRITE_DISABLE, 16);
      chk(deviceStatusFlags, 8'h00);
      cmd(OP_WRITE_ENABLE, 16);
      $display("test permission finished");
      // every read opcode, first at the top address to force the wrap
      for (int i = 0; i < 5; i++) begin
         a = (i == 0) ? LAST_BYTE_ADDR : 10'($urandom_range(0, 535));
         if (rdOps[i] == OP_READ_CFG) a = FIRST_BYTE_ADDR;
         sec = (i < 2) ? 16'($urandom_range(0, 2047)) : 16'h0000;
         rd(rdOps[i], sec, a, RB_READY);
         chk(linkSector, sec);
      end
      cmd(OP_READ_STATUS, 80);
      chk(got[23:0], {RB_READY, 8'h10});
      $display("test reads finished");
      a = 10'($urandom_range(0, 535));
      d = 8'($urandom);
      wrSram(a, d);
      chk(wrQ.size(), 2);
      chk({wrQ[0], wrQ[1]}, {a, d, nextA(a), 8'h00});
      $display("test sram write finished");
      // program a sector, then probe reads, an SRAM write, a transfer and write permission while the array is busy
      sec = 16'($urandom_range(0, 2047));
      spi_host_model_i.frame({OP_WRITE_SECTOR, sec, 80'h0}, 56, got);
      chk(nProg, 1);
      chk(progSector, sec);
      @(posedge clk) arrayBusy <= 1'b1;
      repeat (3) @(posedge clk);
      chk(deviceStatusFlags, 8'h90);
      rd(OP_READ_SECTOR, sec, 10'h005, RB_BUSY);
      rd(OP_READ_SRAM, 16'h0000, a, RB_BUSY);
      wrSram(a, d);
      chk(wrQ.size(), 0);
      cmd(OP_SRAM_TO_PB, 56);
      chk(nXfer, 0);
      cmd(OP_WRITE_DISABLE, 16);
      chk(deviceStatusFlags, 8'h80);
      cmd(OP_WRITE_ENABLE, 16);
      chk(deviceStatusFlags, 8'h90);
      @(posedge clk) arrayBusy <= 1'b0;
      repeat (3) @(posedge clk);
      chk(deviceStatusFlags, 8'h10);
      $display("test busy finished");
      cmd(OP_SRAM_TO_PB, 56);
      chk({nXfer, xferToPb}, {32'd1, 1'b1});
      chk(deviceStatusFlags, 8'hD0);
      pulseDone();
      chk(deviceStatusFlags, 8'h10);
      cmd(OP_PB_TO_SRAM, 56);
      chk({nXfer, xferToPb}, {32'd2, 1'b0});
      pulseDone();
      $display("test transfer finished");
      sec = 16'($urandom);
      spi_host_model_i.frame({OP_WRITE_CFG, sec, 80'h0}, 40, got);
      chk({nCfg, cfgWriteValue}, {32'd1, sec});
      spi_host_model_i.frame({OP_COMPARE, 96'h0}, 88, got);
      chk(got[31:16], RB_READY);
      chk(deviceStatusFlags, 8'h18);
      cmd(OP_WRITE_DISABLE, 16);
      chk(deviceStatusFlags, 8'h08);
      cmd(OP_CLEAR_COMPARE, 16);
      chk(deviceStatusFlags, 8'h00);
      spi_host_model_i.frame({OP_WRITE_SECTOR, 96'h0}, 56, got);
      chk(nProg, 1);
      $display("test compare finished");
      stop_test();
   end
endmodule : tb
